// *** hdl/clk_select_consts.svh ***
`ifndef CLK_SELECT_CONSTS_SVH
`define CLK_SELECT_CONSTS_SVH

// register byte offsets
`define OFS_SYSTEM_CONTROL_REG0  12'h000
`define OFS_PLL_CONTROL_REG0     12'h004
`define OFS_CLOCK_STATUS         12'h008

// system_control_reg0 fields
`define SEL_LSB                  0
`define SEL_MSB                  1
`define WAIT_LSB                 8
`define WAIT_MSB                 10

// pll_control_reg0 fields
`define BYPASS_BIT               0
`define OSC_SRC_BIT              1
`define PLL_INPUT_DIVIDER_FIELD_LSB                 4
`define PLL_INPUT_DIVIDER_FIELD_MSB                 7
`define K2_LSB                   8
`define K2_MSB                   14
`define PRESC_LSB                16
`define PRESC_MSB                25
`define PLL_MULTIPLIER_FIELD_LSB                 26
`define PLL_MULTIPLIER_FIELD_MSB                 31

// clock selector codes
`define SEL_WAKEUP               2'h0
`define SEL_RESERVED             2'h1
`define SEL_OSC_PLL              2'h2
`define SEL_DIRECT               2'h3

// reset values
`define RST_SEL                  2'h0
`define RST_WAIT                 3'h4
`define RST_BYPASS               1'h1
`define RST_PRESC                10'h000
`define RST_PLL_INPUT_DIVIDER_FIELD                 4'h0
`define RST_K2                   7'h00
`define RST_PLL_MULTIPLIER_FIELD                 6'h00

// number of clock sources that are sampled
`define NUM_SRC                  5

`endif

// *** hdl/clk_select_pkg.sv ***
package clk_select_pkg;

   // apb request from the master
   typedef struct packed {
      logic [11:0] paddr;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_s;

   // apb answer to the master
   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } apb_rsp_s;

   // settings handed to the analog pll
   typedef struct packed {
      logic [3:0] pll_input_divider_field;
      logic [5:0] pll_multiplier_field;
      logic [6:0] pll_output_divider_field;
      logic       vco_bypass;
   } pll_cfg_s;

   // flash access handshake state
   typedef enum logic [0:0] {
      FL_IDLE = 1'b0,
      FL_WAIT = 1'b1
   } flash_state_e;

endpackage

// *** hdl/system_clock_source_select.sv ***
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "clk_select_consts.svh"
module system_clock_source_select (
   input  wire logic                     sys_clk,
   input  wire logic                     reset,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire clk_select_pkg::apb_req_s apb_req,
   output      clk_select_pkg::apb_rsp_s apb_rsp,
   input  wire logic                     ext_clock_pin,
   input  wire logic                     crystal_input,
   input  wire logic                     internal_clock,
   input  wire logic                     wakeup_clock,
   input  wire logic                     pll_clock,
   output      logic                     system_clock,
   output      clk_select_pkg::pll_cfg_s pll_cfg,
   input  wire logic                     flash_req,
   input  wire logic                     flash_seq,
   output      logic                     flash_ready
);
   import clk_select_pkg::*;

   // sampled clock sources: ext, crystal, internal, wakeup, pll
   logic [`NUM_SRC-1:0] src_in;
   logic [`NUM_SRC-1:0] src_meta_r;      // first stage, read only by stage two
   logic [`NUM_SRC-1:0] src_sync_r;      // second stage, safe to use
   logic                osc_prev_r;      // prior oscillator level for edge detect

   // register state
   logic [1:0]  sel_r,      sel_nxt;     // clock_source_select
   logic [2:0]  wait_r,     wait_nxt;    // flash_wait_count
   logic        bypass_r,   bypass_nxt;  // vco_bypass
   logic        osc_src_r,  osc_src_nxt; // 1: internal source, 0: crystal
   logic [9:0]  presc_r,    presc_nxt;   // prescaler_divider_field
   logic [3:0]  pll_input_divider_field_r,     pll_input_divider_field_nxt;    // pll_input_divider_field
   logic [6:0]  k2_r,       k2_nxt;      // pll_output_divider_field
   logic [5:0]  pll_multiplier_field_r,     pll_multiplier_field_nxt;    // pll_multiplier_field
   apb_rsp_s    rsp_r,      rsp_nxt;     // bus answer

   // clock generation state
   logic [9:0]  div_cnt_r,  div_cnt_nxt; // prescaler cycle counter
   logic        sysclk_r,   sysclk_nxt;  // generated system clock

   // flash wait state machine
   flash_state_e fl_state_r, fl_state_nxt;
   logic [2:0]   fl_cnt_r,   fl_cnt_nxt;
   logic         fl_rdy_r,   fl_rdy_nxt;

   // helper terms
   logic        setup_ph;                // setup cycle of a transfer
   logic        wr_take;                 // edge at which a write lands
   logic        osc_s;                   // selected oscillator level
   logic        osc_rise;                // oscillator rising edge
   logic [10:0] factor;                  // prescaler_factor
   logic [10:0] half;                    // high portion of divided period
   logic [31:0] rd_val;                  // read mux result
   logic        hit;                     // mapped address

   assign src_in = {pll_clock, wakeup_clock, internal_clock, crystal_input, ext_clock_pin};

   // two-flop synchroniser per source
   // every source is asynchronous to sys_clk and must stay well below half
   // of its rate, or edges are lost and the generated clock aliases
   genvar g;
   generate
      for (g = 0; g < `NUM_SRC; g = g + 1) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               src_meta_r[g] <= 1'b0;
               src_sync_r[g] <= 1'b0;
            end else begin
               src_meta_r[g] <= src_in[g];
               src_sync_r[g] <= src_meta_r[g];
            end
         end
      end
   endgenerate

   // bus phase decode
   // the answer is registered, so every transfer has exactly one access cycle
   assign setup_ph = psel & ~penable;
   assign wr_take  = psel & penable & rsp_r.pready & apb_req.pwrite;

   // oscillator choice and edge detect
   assign osc_s    = osc_src_r ? src_sync_r[2] : src_sync_r[1];
   assign osc_rise = osc_s & ~osc_prev_r;
   assign factor   = {1'b0, presc_r} + 11'h001;
   assign half     = {1'b0, factor[10:1]};

   // read data and address map
   always_comb begin
      rd_val = 32'h0000_0000;
      hit    = 1'b1;
      case (apb_req.paddr)
         `OFS_SYSTEM_CONTROL_REG0: begin
            rd_val[`SEL_MSB:`SEL_LSB]   = sel_r;
            rd_val[`WAIT_MSB:`WAIT_LSB] = wait_r;
         end
         `OFS_PLL_CONTROL_REG0: begin
            rd_val[`BYPASS_BIT]           = bypass_r;
            rd_val[`OSC_SRC_BIT]          = osc_src_r;
            rd_val[`PLL_INPUT_DIVIDER_FIELD_MSB:`PLL_INPUT_DIVIDER_FIELD_LSB]   = pll_input_divider_field_r;
            rd_val[`K2_MSB:`K2_LSB]       = k2_r;
            rd_val[`PRESC_MSB:`PRESC_LSB] = presc_r;
            rd_val[`PLL_MULTIPLIER_FIELD_MSB:`PLL_MULTIPLIER_FIELD_LSB]   = pll_multiplier_field_r;
         end
         `OFS_CLOCK_STATUS: begin
            // live view: clock level, divider count, flash busy
            rd_val[0]     = sysclk_r;
            rd_val[1]     = (fl_state_r == FL_WAIT);
            rd_val[25:16] = div_cnt_r;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // register file and bus answer next values
   always_comb begin
      sel_nxt     = sel_r;
      wait_nxt    = wait_r;
      bypass_nxt  = bypass_r;
      osc_src_nxt = osc_src_r;
      presc_nxt   = presc_r;
      pll_input_divider_field_nxt    = pll_input_divider_field_r;
      k2_nxt      = k2_r;
      pll_multiplier_field_nxt    = pll_multiplier_field_r;
      rsp_nxt     = '0;
      // answer is prepared in setup, shown for one access cycle
      if (setup_ph) begin
         rsp_nxt.pready  = 1'b1;
         rsp_nxt.pslverr = ~hit;
         rsp_nxt.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_val;
      end
      if (wr_take) begin
         case (apb_req.paddr)
            `OFS_SYSTEM_CONTROL_REG0: begin
               // reserved code leaves the selection alone
               if (apb_req.pwdata[`SEL_MSB:`SEL_LSB] != `SEL_RESERVED) begin
                  sel_nxt = apb_req.pwdata[`SEL_MSB:`SEL_LSB];
               end
               wait_nxt = apb_req.pwdata[`WAIT_MSB:`WAIT_LSB];
            end
            `OFS_PLL_CONTROL_REG0: begin
               bypass_nxt  = apb_req.pwdata[`BYPASS_BIT];
               osc_src_nxt = apb_req.pwdata[`OSC_SRC_BIT];
               pll_input_divider_field_nxt    = apb_req.pwdata[`PLL_INPUT_DIVIDER_FIELD_MSB:`PLL_INPUT_DIVIDER_FIELD_LSB];
               k2_nxt      = apb_req.pwdata[`K2_MSB:`K2_LSB];
               presc_nxt   = apb_req.pwdata[`PRESC_MSB:`PRESC_LSB];
               pll_multiplier_field_nxt    = apb_req.pwdata[`PLL_MULTIPLIER_FIELD_MSB:`PLL_MULTIPLIER_FIELD_LSB];
            end
            default: begin
               sel_nxt = sel_r;
            end
         endcase
      end
   end

   // register file and bus answer flops
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sel_r     <= `RST_SEL;
         wait_r    <= `RST_WAIT;
         bypass_r  <= `RST_BYPASS;
         osc_src_r <= 1'b0;
         presc_r   <= `RST_PRESC;
         pll_input_divider_field_r    <= `RST_PLL_INPUT_DIVIDER_FIELD;
         k2_r      <= `RST_K2;
         pll_multiplier_field_r    <= `RST_PLL_MULTIPLIER_FIELD;
         rsp_r     <= '0;
      end else begin
         sel_r     <= sel_nxt;
         wait_r    <= wait_nxt;
         bypass_r  <= bypass_nxt;
         osc_src_r <= osc_src_nxt;
         presc_r   <= presc_nxt;
         pll_input_divider_field_r    <= pll_input_divider_field_nxt;
         k2_r      <= k2_nxt;
         pll_multiplier_field_r    <= pll_multiplier_field_nxt;
         rsp_r     <= rsp_nxt;
      end
   end

   // system clock source mux and prescaler
   // the divided clock only moves on an oscillator rising edge, so its
   // high and low times are whole oscillator periods; an odd factor puts
   // the extra period in the low phase
   // a counter left above a newly written smaller factor wraps at once
   // instead of running through the full ten-bit range
   always_comb begin
      div_cnt_nxt = div_cnt_r;
      sysclk_nxt  = sysclk_r;
      // prescaler counts oscillator periods, wraps at factor
      if (osc_rise) begin
         if ({1'b0, div_cnt_r} >= factor - 11'h001) begin
            div_cnt_nxt = 10'h000;
         end else begin
            div_cnt_nxt = div_cnt_r + 10'h001;
         end
      end
      case (sel_r)
         `SEL_DIRECT: begin
            sysclk_nxt = src_sync_r[0];
         end
         `SEL_OSC_PLL: begin
            if (!bypass_r) begin
               sysclk_nxt = src_sync_r[4];
            end else if (presc_r == 10'h000) begin
               sysclk_nxt = osc_s;
            end else if (osc_rise) begin
               sysclk_nxt = ({1'b0, div_cnt_nxt} < half);
            end
         end
         `SEL_WAKEUP: begin
            sysclk_nxt = src_sync_r[3];
         end
         default: begin
            sysclk_nxt = sysclk_r;
         end
      endcase
   end

   // clock generation flops
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         osc_prev_r <= 1'b0;
         div_cnt_r  <= 10'h000;
         sysclk_r   <= 1'b0;
      end else begin
         osc_prev_r <= osc_s;
         div_cnt_r  <= div_cnt_nxt;
         sysclk_r   <= sysclk_nxt;
      end
   end

   // flash wait states: sequential accesses served at once
   // the wait count is copied when the access starts, so a new setting
   // written during an access only affects the next one
   // requests that arrive while waiting are dropped, not queued
   always_comb begin
      fl_state_nxt = fl_state_r;
      fl_cnt_nxt   = fl_cnt_r;
      fl_rdy_nxt   = 1'b0;
      case (fl_state_r)
         FL_IDLE: begin
            if (flash_req) begin
               if (flash_seq) begin
                  fl_rdy_nxt = 1'b1;
               end else begin
                  fl_state_nxt = FL_WAIT;
                  fl_cnt_nxt   = wait_r;
               end
            end
         end
         FL_WAIT: begin
            // a zero count is treated as one wait
            if (fl_cnt_r <= 3'h1) begin
               fl_rdy_nxt   = 1'b1;
               fl_state_nxt = FL_IDLE;
            end else begin
               fl_cnt_nxt = fl_cnt_r - 3'h1;
            end
         end
         default: begin
            fl_state_nxt = FL_IDLE;
         end
      endcase
   end

   // flash wait flops
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         fl_state_r <= FL_IDLE;
         fl_cnt_r   <= 3'h0;
         fl_rdy_r   <= 1'b0;
      end else begin
         fl_state_r <= fl_state_nxt;
         fl_cnt_r   <= fl_cnt_nxt;
         fl_rdy_r   <= fl_rdy_nxt;
      end
   end

   // bus answer register drives the apb return path
   assign apb_rsp      = rsp_r;
   // generated clock level
   assign system_clock = sysclk_r;
   // completion pulse of a flash access
   assign flash_ready  = fl_rdy_r;
   // pll settings as one word, so a single driver owns the output
   assign pll_cfg      = {pll_input_divider_field_r, pll_multiplier_field_r, k2_r, bypass_r};

endmodule

// *** sim/clk_select_assertions.sv ***
`timescale 1ns/100ps
// port-level checks of the clock selector
module clk_select_assertions (
   input wire logic                     sys_clk,
   input wire logic                     reset,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire clk_select_pkg::apb_req_s apb_req,
   input wire clk_select_pkg::apb_rsp_s apb_rsp,
   input wire logic                     ext_clock_pin,
   input wire logic                     crystal_input,
   input wire logic                     internal_clock,
   input wire logic                     wakeup_clock,
   input wire logic                     pll_clock,
   input wire logic                     system_clock,
   input wire clk_select_pkg::pll_cfg_s pll_cfg,
   input wire logic                     flash_req,
   input wire logic                     flash_seq,
   input wire logic                     flash_ready
);
   import clk_select_pkg::*;
   logic [1:0]  sel_r, sel_nxt; // selector as software left it
   logic [2:0]  ws_r, ws_nxt;   // flash wait count
   logic [2:0]  q_r, q_nxt;     // cycles since last write
   logic [31:0] pc_r, pc_nxt;   // pll control word
   logic        fb_r, fb_nxt;   // flash access in flight
   logic        wr, acc;
   // shadow of the control registers and flash handshake
   always_comb begin
      wr = psel && penable && apb_rsp.pready && apb_req.pwrite;
      acc = flash_req && (!fb_r || flash_ready);
      sel_nxt = sel_r;
      ws_nxt = ws_r;
      pc_nxt = pc_r;
      q_nxt = (q_r == 3'h7) ? q_r : q_r + 3'h1;
      if (wr) begin
         q_nxt = 3'h0;
         if (apb_req.paddr == 12'h004) pc_nxt = apb_req.pwdata;
         if (apb_req.paddr == 12'h000) begin
            ws_nxt = apb_req.pwdata[10:8];
            if (apb_req.pwdata[1:0] != 2'h1) sel_nxt = apb_req.pwdata[1:0];
         end
      end
      fb_nxt = acc ? 1'b1 : (flash_ready ? 1'b0 : fb_r);
   end
   // register the shadow
   always_ff @(posedge sys_clk) begin
      if (reset) {sel_r, ws_r, q_r, pc_r, fb_r} <= {2'h0, 3'h4, 3'h0, 32'h1, 1'b0};
      else {sel_r, ws_r, q_r, pc_r, fb_r} <= {sel_nxt, ws_nxt, q_nxt, pc_nxt, fb_nxt};
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_ready; psel && !penable |=> apb_rsp.pready; endproperty
   a_ready: assert property (p_ready) else $error("no access cycle after setup");
   property p_err; psel && !penable && apb_req.paddr > 12'h008 |=> apb_rsp.pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped access not flagged");
   property p_cfg;
      wr && apb_req.paddr == 12'h004 |-> ##2 pll_cfg == {pc_r[7:4], pc_r[31:26], pc_r[14:8], pc_r[0]};
   endproperty
   a_cfg: assert property (p_cfg) else $error("pll settings wrong");
   property p_direct; q_r == 3'h7 && sel_r == 2'h3 |-> system_clock == $past(ext_clock_pin, 3); endproperty
   a_direct: assert property (p_direct) else $error("direct drive wrong");
   property p_wake; q_r == 3'h7 && sel_r == 2'h0 |-> system_clock == $past(wakeup_clock, 3); endproperty
   a_wake: assert property (p_wake) else $error("wakeup clock wrong");
   property p_pll; q_r == 3'h7 && sel_r == 2'h2 && !pc_r[0] |-> system_clock == $past(pll_clock, 3); endproperty
   a_pll: assert property (p_pll) else $error("pll clock wrong");
   property p_pass;
      q_r == 3'h7 && sel_r == 2'h2 && pc_r[0] && pc_r[25:16] == 10'h000
         |-> system_clock == (pc_r[1] ? $past(internal_clock, 3) : $past(crystal_input, 3));
   endproperty
   a_pass: assert property (p_pass) else $error("undivided oscillator wrong");
   property p_seq; acc && flash_seq |=> flash_ready; endproperty
   a_seq: assert property (p_seq) else $error("sequential access late");
   property p_nseq; acc && !flash_seq && ws_r == 3'h4 |=> !flash_ready [*4] ##1 flash_ready; endproperty
   a_nseq: assert property (p_nseq) else $error("wait states wrong");
   c_div: cover property (sel_r == 2'h2 && pc_r[0] && pc_r[25:16] == 10'h3FF && system_clock);
   c_err: cover property (apb_rsp.pslverr);
   c_nseq: cover property (acc && !flash_seq);
endmodule

// *** sim/clk_source_model.sv ***
`timescale 1ns/100ps
// free running source clock; offset keeps edges off the sampling grid
module clk_source_model #(
   parameter real PER = 40.0,
   parameter real HI  = 20.0
) (
   output logic clk
);
   // fixed period and high time
   initial begin
      clk = 1'b0;
      #1.3;
      forever begin
         clk = 1'b1;
         #(HI);
         clk = 1'b0;
         #(PER - HI);
      end
   end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   import clk_select_pkg::*;
   logic        sys_clk, reset, psel, penable, flash_req, flash_seq;
   logic        ext, xtal, intc, wuc, pllc, sclk, frdy, er;
   apb_req_s    req;
   apb_rsp_s    rsp;
   pll_cfg_s    pcfg;
   logic [31:0] rd;
   int          err_total, cmp_count;
   clk_source_model #(.PER(40.0), .HI(10.0)) ext_src (.clk(ext));
   clk_source_model #(.PER(60.0), .HI(20.0)) xtal_src (.clk(xtal));
   clk_source_model #(.PER(50.0), .HI(25.0)) int_src (.clk(intc));
   clk_source_model #(.PER(100.0), .HI(50.0)) wu_src (.clk(wuc));
   clk_source_model #(.PER(30.0), .HI(15.0)) pll_src (.clk(pllc));
   system_clock_source_select system_clock_source_select_inst (
      .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .apb_req(req),
      .apb_rsp(rsp), .ext_clock_pin(ext), .crystal_input(xtal), .internal_clock(intc),
      .wakeup_clock(wuc), .pll_clock(pllc), .system_clock(sclk), .pll_cfg(pcfg),
      .flash_req(flash_req), .flash_seq(flash_seq), .flash_ready(frdy));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      req <= '{paddr: a, pwrite: w, pwdata: d};
      @(posedge sys_clk);
      penable <= 1'b1;
      // look mid-cycle; the edge after a high pready ends the transfer
      @(negedge sys_clk);
      while (rsp.pready !== 1'b1) @(negedge sys_clk);
      rd = rsp.prdata;
      er = rsp.pslverr;
      @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // high and low time of the second full system clock period
   task automatic measure(input string nm, input int hi, input int lo);
      int h, l, n;
      repeat (8) @(negedge sys_clk);
      for (n = 0; n < 20000 && sclk !== 1'b0; n++) @(negedge sys_clk);
      for (n = 0; n < 20000 && sclk !== 1'b1; n++) @(negedge sys_clk);
      repeat (2) begin
         for (h = 0; h < 20000 && sclk === 1'b1; h++) @(negedge sys_clk);
         for (l = 0; l < 20000 && sclk === 1'b0; l++) @(negedge sys_clk);
      end
      chk({nm, " high"}, hi, h);
      chk({nm, " low"}, lo, l);
   endtask
   // one flash access, cycles counted until ready
   task automatic flash(input logic s, input int lat);
      int n;
      @(posedge sys_clk);
      flash_req <= 1'b1;
      flash_seq <= s;
      @(posedge sys_clk);
      flash_req <= 1'b0;
      // count cycles from the request cycle, looked at mid-cycle
      n = 1;
      @(negedge sys_clk);
      while (n < 20 && frdy !== 1'b1) begin
         n++;
         @(negedge sys_clk);
      end
      chk("flash latency", lat, n);
   endtask
   task automatic t_reset;
      apb(12'h000, 1'b0, 32'h0);
      chk("ctrl0", 32'h0000_0400, rd);
      apb(12'h004, 1'b0, 32'h0);
      chk("pll ctrl", 32'h0000_0001, rd);
      chk("pll cfg", 32'h0000_0001, {14'h0, pcfg});
      apb(12'h00C, 1'b0, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
   endtask
   // external pin 40 ns with 10 ns high gives 2 high, 6 low
   task automatic t_direct;
      apb(12'h000, 1'b1, 32'h0000_0403);
      measure("direct", 2, 6);
      apb(12'h000, 1'b1, 32'h0000_0401);
      apb(12'h000, 1'b0, 32'h0);
      chk("reserved", 32'h0000_0403, rd);
      measure("kept", 2, 6);
   endtask
   task automatic t_presc(input logic [9:0] f, input logic src, input int hi, input int lo);
      apb(12'h004, 1'b1, {6'h00, f, 14'h0, src, 1'b1});
      apb(12'h000, 1'b1, 32'h0000_0402);
      measure("prescaler", hi, lo);
   endtask
   task automatic t_pll;
      apb(12'h004, 1'b1, 32'hFC00_7F50);
      repeat (2) @(posedge sys_clk);
      chk("pll cfg", {14'h0, 4'h5, 6'h3F, 7'h7F, 1'b0}, {14'h0, pcfg});
      measure("pll", 3, 3);
   endtask
   task automatic t_flash;
      int w;
      for (w = 1; w <= 4; w++) begin
         apb(12'h000, 1'b1, 32'(w) << 8);
         flash(1'b0, w + 1);
         flash(1'b1, 1);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      wrap_up;
   end
   initial begin
      {psel, penable, flash_req, flash_seq, req} = '0;
      reset = 1'b1;
      err_total = 0;
      cmp_count = 0;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset;
      t_direct;
      t_presc(10'h000, 1'b0, 4, 8);
      t_presc(10'h002, 1'b0, 1 * 12, 2 * 12);
      t_presc(10'h003, 1'b1, 2 * 10, 2 * 10);
      t_presc(10'h3FF, 1'b0, 512 * 12, 512 * 12);
      t_pll;
      apb(12'h000, 1'b1, 32'h0000_0400);
      measure("wakeup", 10, 10);
      t_flash;
      wrap_up;
   end
endmodule
bind system_clock_source_select clk_select_assertions sva_inst (
   .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .ext_clock_pin(ext_clock_pin), .crystal_input(crystal_input),
   .internal_clock(internal_clock), .wakeup_clock(wakeup_clock), .pll_clock(pll_clock),
   .system_clock(system_clock), .pll_cfg(pll_cfg), .flash_req(flash_req),
   .flash_seq(flash_seq), .flash_ready(flash_ready));
